// ### verilog/pllcs_defines.vh
/*
  Register indices, field positions, reset values and widths for the
  clock-select control block. Assumes byte address = 4 * index on APB.
*/
`ifndef PLLCS_DEFINES_VH
`define PLLCS_DEFINES_VH

// Register indices (byte address is four times the index)
`define PLLCS_IDX_OSC_CTRL 22'h3F0001
`define PLLCS_IDX_PLL_A_DIV 22'h3F00A8
`define PLLCS_IDX_PLL_A_CTRL 22'h3F00AA
`define PLLCS_IDX_PLL_B_DIV 22'h3F00AC
`define PLLCS_IDX_PLL_B_CTRL 22'h3F00AE
`define PLLCS_IDX_IRQ_STATUS 22'h3F00B0
`define PLLCS_IDX_IRQ_MASK 22'h3F00B1

// Reset values
`define PLLCS_RST_OSC_CTRL 8'h00
`define PLLCS_RST_PLL_DIV 16'h0000
`define PLLCS_RST_PLL_CTRL 8'h00
`define PLLCS_RST_IRQ 4'h0

// Control register fields
`define PLLCS_BIT_ENABLE 0
`define PLLCS_BIT_LOCK 1
`define PLLCS_BIT_MAIN_SEL 2
`define PLLCS_USB_LSB 2
`define PLLCS_USB_MSB 3
`define PLLCS_AUDIO_LSB 4
`define PLLCS_AUDIO_MSB 6

// Oscillator control fields
`define PLLCS_BIT_SYS_SEL 0
`define PLLCS_BIT_SUB_STOP 2
`define PLLCS_BIT_MAIN_STOP 3

// Divider fields
`define PLLCS_S_LSB 0
`define PLLCS_S_MSB 1
`define PLLCS_M_LSB 2
`define PLLCS_M_MSB 15
`define PLLCS_M_OFFSET 15'h0002

// Audio clock select codes
`define PLLCS_AUDIO_ZERO 3'h5

// USB clock select code with no source behind it
`define PLLCS_USB_NONE 2'h3

// Interrupt status / mask bits
`define PLLCS_IRQ_A_LOCKED 0
`define PLLCS_IRQ_A_LOST 1
`define PLLCS_IRQ_B_LOCKED 2
`define PLLCS_IRQ_B_LOST 3
`define PLLCS_IRQ_W 4

`endif

// ### verilog/pllcs_lock_sync.v
/*
  Lock-detect synchroniser with edge pulses.
  Assumes lock_async comes from the analog PLL, outside the clk domain.
*/
`timescale 1ns/100ps
module pllcs_lock_sync (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Raw detector level
  input wire lock_async,
  // Synchronised level and edges
  output reg lock_level,
  output wire rise_pulse,
  output wire fall_pulse
);

  reg meta_reg;
  reg sync_reg;

  // First stage feeds only the second
  always @(posedge clk) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      lock_level <= 1'b0;
    end else begin
      meta_reg <= lock_async;
      sync_reg <= meta_reg;
      lock_level <= sync_reg;
    end
  end

  assign rise_pulse = sync_reg & ~lock_level;
  assign fall_pulse = ~sync_reg & lock_level;

endmodule

// ### verilog/pllcs_top.v
/*
  Clock-source and PLL setting control with APB register access,
  lock-detect flags and lock-change interrupt.
  Assumes the analog PLLs, oscillators and glitch-free clock muxes sit
  outside and take the select, enable and divider outputs as levels.
*/
// Added by the designer: the APB register port.
`timescale 1ns/100ps
`include "pllcs_defines.vh"
module pllcs_top #(
  parameter ADDR_W = 24
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Lock detectors (asynchronous)
  input wire pll_a_lock_in,
  input wire pll_b_lock_in,
  // PLL A controls
  output reg pll_a_enable,
  output reg [13:0] pll_a_m,
  output reg [1:0] pll_a_s,
  output reg [14:0] pll_a_feedback_div,
  // PLL B controls
  output reg pll_b_enable,
  output reg [13:0] pll_b_m,
  output reg [1:0] pll_b_s,
  output reg [14:0] pll_b_feedback_div,
  // Clock selects
  output reg main_clk_sel_pll,
  output reg [2:0] audio_clk_sel,
  output reg [1:0] usb_clk_sel,
  output reg usb_clk_valid,
  output reg sys_clk_sel_sub,
  // Oscillator stops
  output reg main_osc_stop,
  output reg sub_osc_stop,
  // Interrupt
  output reg irq
);

  localparam [2:0] SEL_OSC = 3'h0;
  localparam [2:0] SEL_A_DIV = 3'h1;
  localparam [2:0] SEL_A_CTRL = 3'h2;
  localparam [2:0] SEL_B_DIV = 3'h3;
  localparam [2:0] SEL_B_CTRL = 3'h4;
  localparam [2:0] SEL_STAT = 3'h5;
  localparam [2:0] SEL_MASK = 3'h6;
  localparam [2:0] SEL_NONE = 3'h7;

  // Maps a word index to a register number
  function [2:0] reg_decode;
    input [21:0] idx;
    begin
      case (idx)
        `PLLCS_IDX_OSC_CTRL: reg_decode = SEL_OSC;
        `PLLCS_IDX_PLL_A_DIV: reg_decode = SEL_A_DIV;
        `PLLCS_IDX_PLL_A_CTRL: reg_decode = SEL_A_CTRL;
        `PLLCS_IDX_PLL_B_DIV: reg_decode = SEL_B_DIV;
        `PLLCS_IDX_PLL_B_CTRL: reg_decode = SEL_B_CTRL;
        `PLLCS_IDX_IRQ_STATUS: reg_decode = SEL_STAT;
        `PLLCS_IDX_IRQ_MASK: reg_decode = SEL_MASK;
        default: reg_decode = SEL_NONE;
      endcase
    end
  endfunction

  // Feedback division M + 2 from a divider word
  function [14:0] feedback_div;
    input [15:0] word;
    begin
      feedback_div = {1'b0, word[`PLLCS_M_MSB:`PLLCS_M_LSB]} + `PLLCS_M_OFFSET;
    end
  endfunction

  // Byte-lane merge of a 16-bit register
  function [15:0] lane_merge;
    input [15:0] old_val;
    input [15:0] new_val;
    input [1:0] strb;
    begin
      lane_merge[7:0] = strb[0] ? new_val[7:0] : old_val[7:0];
      lane_merge[15:8] = strb[1] ? new_val[15:8] : old_val[15:8];
    end
  endfunction

  // Register storage
  reg [7:0] osc_ctrl_reg;
  reg [7:0] osc_ctrl_next;
  reg [15:0] pll_a_div_reg;
  reg [15:0] pll_a_div_next;
  reg [15:0] pll_b_div_reg;
  reg [15:0] pll_b_div_next;
  reg [2:0] pll_a_ctrl_reg;
  reg [2:0] pll_a_ctrl_next;
  reg [6:0] pll_b_ctrl_reg;
  reg [6:0] pll_b_ctrl_next;
  reg [`PLLCS_IRQ_W-1:0] irq_status_reg;
  reg [`PLLCS_IRQ_W-1:0] irq_status_next;
  reg [`PLLCS_IRQ_W-1:0] irq_mask_reg;
  reg [`PLLCS_IRQ_W-1:0] irq_mask_next;

  // Bus and read path
  reg [31:0] rdata_next;
  wire [2:0] reg_sel;
  wire acc_phase;
  wire done;
  wire wr_done;
  wire rd_done;
  wire [`PLLCS_IRQ_W-1:0] irq_events;

  // Synchronised lock levels and edges
  wire a_lock;
  wire a_rise;
  wire a_fall;
  wire b_lock;
  wire b_rise;
  wire b_fall;

  pllcs_lock_sync u_sync_a (
    .clk(clk),
    .rst(rst),
    .lock_async(pll_a_lock_in),
    .lock_level(a_lock),
    .rise_pulse(a_rise),
    .fall_pulse(a_fall)
  );

  pllcs_lock_sync u_sync_b (
    .clk(clk),
    .rst(rst),
    .lock_async(pll_b_lock_in),
    .lock_level(b_lock),
    .rise_pulse(b_rise),
    .fall_pulse(b_fall)
  );

  assign reg_sel = reg_decode(paddr[23:2]);
  assign acc_phase = psel & penable;
  // One wait state: pready rises in the second access cycle
  assign done = acc_phase & pready;
  assign wr_done = done & pwrite & (reg_sel != SEL_NONE);
  assign rd_done = done & ~pwrite;

  assign irq_events[`PLLCS_IRQ_A_LOCKED] = a_rise;
  assign irq_events[`PLLCS_IRQ_A_LOST] = a_fall;
  assign irq_events[`PLLCS_IRQ_B_LOCKED] = b_rise;
  assign irq_events[`PLLCS_IRQ_B_LOST] = b_fall;

  // Register write and status update
  always @* begin
    osc_ctrl_next = osc_ctrl_reg;
    pll_a_div_next = pll_a_div_reg;
    pll_b_div_next = pll_b_div_reg;
    pll_a_ctrl_next = pll_a_ctrl_reg;
    pll_b_ctrl_next = pll_b_ctrl_reg;
    irq_mask_next = irq_mask_reg;
    irq_status_next = irq_status_reg;
    if (wr_done) begin
      case (reg_sel)
        SEL_OSC: begin
          if (pstrb[0]) begin
            osc_ctrl_next[`PLLCS_BIT_MAIN_STOP] = pwdata[`PLLCS_BIT_MAIN_STOP];
            osc_ctrl_next[`PLLCS_BIT_SUB_STOP] = pwdata[`PLLCS_BIT_SUB_STOP];
            osc_ctrl_next[`PLLCS_BIT_SYS_SEL] = pwdata[`PLLCS_BIT_SYS_SEL];
          end
        end
        SEL_A_DIV: begin
          pll_a_div_next = lane_merge(pll_a_div_reg, pwdata[15:0], pstrb[1:0]);
        end
        SEL_B_DIV: begin
          pll_b_div_next = lane_merge(pll_b_div_reg, pwdata[15:0], pstrb[1:0]);
        end
        SEL_A_CTRL: begin
          // Lock position is not stored; it always shows the detector
          if (pstrb[0]) begin
            pll_a_ctrl_next[`PLLCS_BIT_MAIN_SEL] = pwdata[`PLLCS_BIT_MAIN_SEL];
            pll_a_ctrl_next[`PLLCS_BIT_ENABLE] = pwdata[`PLLCS_BIT_ENABLE];
            pll_a_ctrl_next[`PLLCS_BIT_LOCK] = 1'b0;
          end
        end
        SEL_B_CTRL: begin
          if (pstrb[0]) begin
            pll_b_ctrl_next[`PLLCS_AUDIO_MSB:`PLLCS_AUDIO_LSB] =
              pwdata[`PLLCS_AUDIO_MSB:`PLLCS_AUDIO_LSB];
            pll_b_ctrl_next[`PLLCS_USB_MSB:`PLLCS_USB_LSB] =
              pwdata[`PLLCS_USB_MSB:`PLLCS_USB_LSB];
            pll_b_ctrl_next[`PLLCS_BIT_ENABLE] = pwdata[`PLLCS_BIT_ENABLE];
            pll_b_ctrl_next[`PLLCS_BIT_LOCK] = 1'b0;
          end
        end
        SEL_MASK: begin
          if (pstrb[0]) begin
            irq_mask_next = pwdata[`PLLCS_IRQ_W-1:0];
          end
        end
        default: begin
          irq_mask_next = irq_mask_reg;
        end
      endcase
    end
    // Read clears status; a new event in the same cycle still sets
    if (rd_done && reg_sel == SEL_STAT) begin
      irq_status_next = {`PLLCS_IRQ_W{1'b0}};
    end
    irq_status_next = irq_status_next | irq_events;
  end

  // Read data for the current address
  always @* begin
    rdata_next = 32'h0000_0000;
    case (reg_sel)
      SEL_OSC: begin
        rdata_next[7:0] = osc_ctrl_reg;
      end
      SEL_A_DIV: begin
        rdata_next[15:0] = pll_a_div_reg;
      end
      SEL_B_DIV: begin
        rdata_next[15:0] = pll_b_div_reg;
      end
      SEL_A_CTRL: begin
        rdata_next[2:0] = pll_a_ctrl_reg;
        rdata_next[`PLLCS_BIT_LOCK] = a_lock;
      end
      SEL_B_CTRL: begin
        rdata_next[6:0] = pll_b_ctrl_reg;
        rdata_next[`PLLCS_BIT_LOCK] = b_lock;
      end
      SEL_STAT: begin
        // An event in the cycle before pready rises must be reported too
        rdata_next[`PLLCS_IRQ_W-1:0] = irq_status_reg | irq_events;
      end
      SEL_MASK: begin
        rdata_next[`PLLCS_IRQ_W-1:0] = irq_mask_reg;
      end
      default: begin
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  // APB handshake; prdata registered on the same edge that pready rises
  always @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc_phase & ~pready;
      if (acc_phase && !pready) begin
        pslverr <= (reg_sel == SEL_NONE);
        prdata <= pwrite ? 32'h0000_0000 : rdata_next;
      end else begin
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Register state
  always @(posedge clk) begin
    if (rst) begin
      osc_ctrl_reg <= `PLLCS_RST_OSC_CTRL;
      pll_a_div_reg <= `PLLCS_RST_PLL_DIV;
      pll_b_div_reg <= `PLLCS_RST_PLL_DIV;
      pll_a_ctrl_reg <= 3'h0;
      pll_b_ctrl_reg <= 7'h00;
      irq_status_reg <= `PLLCS_RST_IRQ;
      irq_mask_reg <= `PLLCS_RST_IRQ;
    end else begin
      osc_ctrl_reg <= osc_ctrl_next;
      pll_a_div_reg <= pll_a_div_next;
      pll_b_div_reg <= pll_b_div_next;
      pll_a_ctrl_reg <= pll_a_ctrl_next;
      pll_b_ctrl_reg <= pll_b_ctrl_next;
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  // Outputs follow the next register values so they change with the write
  always @(posedge clk) begin
    if (rst) begin
      pll_a_enable <= 1'b0;
      pll_a_m <= 14'h0000;
      pll_a_s <= 2'h0;
      pll_a_feedback_div <= `PLLCS_M_OFFSET;
      pll_b_enable <= 1'b0;
      pll_b_m <= 14'h0000;
      pll_b_s <= 2'h0;
      pll_b_feedback_div <= `PLLCS_M_OFFSET;
      main_clk_sel_pll <= 1'b0;
      audio_clk_sel <= 3'h0;
      usb_clk_sel <= 2'h0;
      usb_clk_valid <= 1'b1;
      sys_clk_sel_sub <= 1'b0;
      main_osc_stop <= 1'b0;
      sub_osc_stop <= 1'b0;
      irq <= 1'b0;
    end else begin
      pll_a_enable <= pll_a_ctrl_next[`PLLCS_BIT_ENABLE];
      pll_b_enable <= pll_b_ctrl_next[`PLLCS_BIT_ENABLE];
      pll_a_m <= pll_a_div_next[`PLLCS_M_MSB:`PLLCS_M_LSB];
      pll_a_s <= pll_a_div_next[`PLLCS_S_MSB:`PLLCS_S_LSB];
      pll_a_feedback_div <= feedback_div(pll_a_div_next);
      pll_b_m <= pll_b_div_next[`PLLCS_M_MSB:`PLLCS_M_LSB];
      pll_b_s <= pll_b_div_next[`PLLCS_S_MSB:`PLLCS_S_LSB];
      pll_b_feedback_div <= feedback_div(pll_b_div_next);
      main_clk_sel_pll <= pll_a_ctrl_next[`PLLCS_BIT_MAIN_SEL];
      // Codes above the zero source are held at zero to avoid a stray clock
      if (pll_b_ctrl_next[`PLLCS_AUDIO_MSB:`PLLCS_AUDIO_LSB] > `PLLCS_AUDIO_ZERO) begin
        audio_clk_sel <= `PLLCS_AUDIO_ZERO;
      end else begin
        audio_clk_sel <= pll_b_ctrl_next[`PLLCS_AUDIO_MSB:`PLLCS_AUDIO_LSB];
      end
      usb_clk_sel <= pll_b_ctrl_next[`PLLCS_USB_MSB:`PLLCS_USB_LSB];
      usb_clk_valid <=
        (pll_b_ctrl_next[`PLLCS_USB_MSB:`PLLCS_USB_LSB] != `PLLCS_USB_NONE);
      sys_clk_sel_sub <= osc_ctrl_next[`PLLCS_BIT_SYS_SEL];
      main_osc_stop <= osc_ctrl_next[`PLLCS_BIT_MAIN_STOP];
      sub_osc_stop <= osc_ctrl_next[`PLLCS_BIT_SUB_STOP];
      irq <= |(irq_status_next & irq_mask_next);
    end
  end

endmodule

// ### verilog/pllcs_end.v
`timescale 1ns/100ps

// ### test/pllcs_chk.sv
/* Port-level assertions for pllcs_top.
   Sees only top ports; attached by the bind after the module. */
`timescale 1ns/100ps
module pllcs_chk (
  // Clock and reset
  input wire clk,
  input wire rst,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Controls
  input wire pll_a_enable,
  input wire [13:0] pll_a_m,
  input wire [14:0] pll_a_feedback_div,
  input wire [13:0] pll_b_m,
  input wire [14:0] pll_b_feedback_div,
  input wire main_clk_sel_pll,
  input wire [2:0] audio_clk_sel,
  input wire [1:0] usb_clk_sel,
  input wire usb_clk_valid,
  input wire irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without access phase");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  a_fb_div_a: assert property (pll_a_feedback_div == {1'b0, pll_a_m} + 15'h0002)
    else $error("feedback A not M plus 2");
  a_fb_div_b: assert property (pll_b_feedback_div == {1'b0, pll_b_m} + 15'h0002)
    else $error("feedback B not M plus 2");
  a_audio_range: assert property (audio_clk_sel <= 3'h5)
    else $error("audio select code out of range");
  a_usb_flag: assert property (usb_clk_valid == (usb_clk_sel != 2'h3))
    else $error("usb valid flag wrong");
  a_enable_src: assert property ($changed(pll_a_enable) |->
    $past(pready && pwrite) || $past(rst))
    else $error("PLL A enable changed without write");
  a_main_sel_src: assert property ($changed(main_clk_sel_pll) |->
    $past(pready && pwrite) || $past(rst))
    else $error("main select changed without write");
  a_reset_clear: assert property (disable iff (1'b0) rst |=> !irq && !pll_a_enable && !pready)
    else $error("outputs not cleared by reset");

  c_slverr: cover property (pslverr);
  c_irq: cover property ($rose(irq));
  c_audio_zero: cover property (audio_clk_sel == 3'h5);
endmodule

bind pllcs_top pllcs_chk u_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pll_a_enable(pll_a_enable), .pll_a_m(pll_a_m), .pll_a_feedback_div(pll_a_feedback_div),
  .pll_b_m(pll_b_m), .pll_b_feedback_div(pll_b_feedback_div),
  .main_clk_sel_pll(main_clk_sel_pll), .audio_clk_sel(audio_clk_sel),
  .usb_clk_sel(usb_clk_sel), .usb_clk_valid(usb_clk_valid), .irq(irq));

// ### test/pllcs_tb.sv
/* Self-checking bench for pllcs_top.
   Assumes a 200 MHz clock and an APB master in this bench. */
`timescale 1ns/100ps
`include "pllcs_defines.vh"
module tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [23:0] paddr = 24'h000000;
  reg [31:0] pwdata = 32'h00000000;
  reg lock_a = 1'b0, lock_b = 1'b0;
  reg [3:0] strb = 4'hF;
  wire [31:0] prdata;
  wire pready, pslverr, a_en, b_en, main_sel, usb_ok, sys_sub, main_stop, sub_stop, irq;
  wire [13:0] a_m, b_m;
  wire [1:0] a_s, b_s, usb_sel;
  wire [14:0] a_fb, b_fb;
  wire [2:0] audio_sel;
  reg [31:0] rd;
  reg err;
  integer failures = 0, checks = 0, i;

  pllcs_top uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pll_a_lock_in(lock_a), .pll_b_lock_in(lock_b),
    .pll_a_enable(a_en), .pll_a_m(a_m), .pll_a_s(a_s), .pll_a_feedback_div(a_fb),
    .pll_b_enable(b_en), .pll_b_m(b_m), .pll_b_s(b_s), .pll_b_feedback_div(b_fb),
    .main_clk_sel_pll(main_sel), .audio_clk_sel(audio_sel), .usb_clk_sel(usb_sel),
    .usb_clk_valid(usb_ok), .sys_clk_sel_sub(sys_sub), .main_osc_stop(main_stop),
    .sub_osc_stop(sub_stop), .irq(irq));

  always #2.5 clk = ~clk;

  task results;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task chk(input string name, input [31:0] exp, input [31:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("mismatch %0s exp %h got %h", name, exp, got);
    end
  endtask

  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask

  // Bounded wait: slave latency is not assumed
  task apb(input w, input [21:0] idx, input [31:0] d);
    integer n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n = n + 1;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) failures = failures + 1;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rchk(input [21:0] idx, input [31:0] exp, input string name);
    apb(1'b0, idx, 32'h0);
    chk(name, exp, rd);
  endtask

  task t_reset;
    rchk(`PLLCS_IDX_OSC_CTRL, 32'h0, "osc");
    rchk(`PLLCS_IDX_PLL_A_DIV, 32'h0, "a_div");
    rchk(`PLLCS_IDX_PLL_A_CTRL, 32'h0, "a_ctrl");
    rchk(`PLLCS_IDX_PLL_B_DIV, 32'h0, "b_div");
    rchk(`PLLCS_IDX_PLL_B_CTRL, 32'h0, "b_ctrl");
    chk("a_fb", 32'h2, a_fb);
    chk("usb_ok", 32'h1, usb_ok);
    $display("test reset done");
  endtask

  task t_pll_a;
    apb(1'b1, `PLLCS_IDX_PLL_A_CTRL, 32'h03);
    tick(2);
    chk("a_en", 32'h1, a_en);
    chk("main_sel", 32'h0, main_sel);
    rchk(`PLLCS_IDX_PLL_A_CTRL, 32'h01, "a_ctrl");
    lock_a <= 1'b1;
    tick(5);
    rchk(`PLLCS_IDX_PLL_A_CTRL, 32'h03, "a_lock");
    // Source switched only once the loop reports lock
    apb(1'b1, `PLLCS_IDX_PLL_A_CTRL, 32'h05);
    tick(2);
    chk("main_sel", 32'h1, main_sel);
    rchk(`PLLCS_IDX_PLL_A_CTRL, 32'h07, "a_ctrl");
    apb(1'b1, `PLLCS_IDX_PLL_A_CTRL, 32'h00);
    tick(2);
    chk("a_en", 32'h0, a_en);
    chk("main_sel", 32'h0, main_sel);
    rchk(`PLLCS_IDX_PLL_A_CTRL, 32'h02, "a_ctrl");
    $display("test pll_a done");
  endtask

  task t_pll_b;
    lock_b <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      apb(1'b1, `PLLCS_IDX_PLL_B_CTRL, (i << 4) | ((i % 4) << 2) | 1);
      tick(2);
      chk("audio", (i > 5) ? 5 : i, audio_sel);
      chk("usb", i % 4, usb_sel);
      chk("usb_ok", (i % 4) != 3, usb_ok);
      chk("b_en", 32'h1, b_en);
    end
    apb(1'b1, `PLLCS_IDX_PLL_B_CTRL, 32'h49);
    rchk(`PLLCS_IDX_PLL_B_CTRL, 32'h4B, "b_ctrl");
    apb(1'b1, `PLLCS_IDX_PLL_B_CTRL, 32'h00);
    tick(2);
    chk("b_en", 32'h0, b_en);
    $display("test pll_b done");
  endtask

  task t_div;
    apb(1'b1, `PLLCS_IDX_PLL_A_DIV, 32'hFFFF);
    apb(1'b1, `PLLCS_IDX_PLL_B_DIV, 32'h0006);
    tick(2);
    chk("a_m", 32'h3FFF, a_m);
    chk("a_s", 32'h3, a_s);
    chk("a_fb", 32'h4001, a_fb);
    chk("b_m", 32'h1, b_m);
    chk("b_s", 32'h2, b_s);
    chk("b_fb", 32'h3, b_fb);
    rchk(`PLLCS_IDX_PLL_A_DIV, 32'hFFFF, "a_div");
    // Upper lane only: the low byte must keep its value
    strb <= 4'h2;
    apb(1'b1, `PLLCS_IDX_PLL_A_DIV, 32'h1234);
    strb <= 4'hF;
    rchk(`PLLCS_IDX_PLL_A_DIV, 32'h12FF, "a_div_lane");
    $display("test div done");
  endtask

  task t_osc;
    apb(1'b1, `PLLCS_IDX_OSC_CTRL, 32'hFF);
    tick(2);
    chk("main_stop", 32'h1, main_stop);
    chk("sub_stop", 32'h1, sub_stop);
    chk("sys_sub", 32'h1, sys_sub);
    rchk(`PLLCS_IDX_OSC_CTRL, 32'h0D, "osc");
    apb(1'b1, `PLLCS_IDX_OSC_CTRL, 32'h04);
    tick(2);
    chk("main_stop", 32'h0, main_stop);
    chk("sub_stop", 32'h1, sub_stop);
    chk("sys_sub", 32'h0, sys_sub);
    strb <= 4'hE;
    apb(1'b1, `PLLCS_IDX_OSC_CTRL, 32'h08);
    strb <= 4'hF;
    tick(2);
    chk("main_stop_strb", 32'h0, main_stop);
    rchk(22'h3F00B5, 32'h0, "unmapped");
    chk("slverr", 32'h1, err);
    $display("test osc done");
  endtask

  task t_rst;
    apb(1'b1, `PLLCS_IDX_OSC_CTRL, 32'h08);
    rst <= 1'b1;
    tick(5);
    rst <= 1'b0;
    tick(1);
    chk("main_stop_rst", 32'h0, main_stop);
    chk("a_en_rst", 32'h0, a_en);
    rchk(`PLLCS_IDX_OSC_CTRL, 32'h0, "osc_rst");
    $display("test mid reset done");
  endtask

  task t_irq;
    apb(1'b0, `PLLCS_IDX_IRQ_STATUS, 32'h0);
    apb(1'b1, `PLLCS_IDX_IRQ_MASK, 32'h1);
    lock_a <= 1'b0;
    tick(6);
    chk("irq_masked", 32'h0, irq);
    lock_a <= 1'b1;
    tick(6);
    chk("irq", 32'h1, irq);
    rchk(`PLLCS_IDX_IRQ_STATUS, 32'h3, "status");
    tick(2);
    chk("irq", 32'h0, irq);
    rchk(`PLLCS_IDX_IRQ_STATUS, 32'h0, "status");
    $display("test irq done");
  endtask

  initial begin
    #100000;
    failures = failures + 1;
    results;
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_pll_a;
    t_pll_b;
    t_div;
    t_osc;
    t_rst;
    t_irq;
    results;
  end
endmodule
